// *** bench/ssf_slave_model.sv ***
`timescale 1ns/10ps
module ssf_slave_model (
   // clock
   input  wire logic              i_ref_clk,
   // wide slave slots
   input  wire logic [3:0]        i_valid,
   input  wire logic [3:0]        i_wr,
   input  wire logic [3:0][5:0]   i_mstid,
   input  wire logic [3:0][31:0]  i_addr,
   input  wire logic [3:0][6:0]   i_bytes,
   input  wire logic [3:0][63:0]  i_wdata,
   output logic [3:0]             o_rd_ready,
   output logic [3:0]             o_wr_ready,
   // configuration side
   input  wire logic              i_c_valid,
   input  wire logic              i_c_wr,
   input  wire logic [5:0]        i_c_mstid,
   input  wire logic [31:0]       i_c_addr,
   input  wire logic [31:0]       i_c_wdata,
   output logic                   o_c_ready
);
   logic [112:0] slot_q[$];
   logic [70:0]  cfg_q[$];
   initial begin
      o_rd_ready = '1;
      o_wr_ready = '1;
      o_c_ready  = 1'b1;
   end
   // random stalls keep commands held across several edges
   always @(negedge i_ref_clk) begin
      o_rd_ready <= 4'($urandom | $urandom);
      o_wr_ready <= 4'($urandom | $urandom);
      o_c_ready  <= 1'($urandom | $urandom);
   end
   always @(posedge i_ref_clk) begin
      for (int s = 0; s < 4; s++)
         if (i_valid[s] && (i_wr[s] ? o_wr_ready[s] : o_rd_ready[s]))
            slot_q.push_back({i_wr[s], 3'(s), i_mstid[s], i_addr[s],
                              i_bytes[s], i_wdata[s]});
      if (i_c_valid && o_c_ready)
         cfg_q.push_back({i_c_wr, i_c_mstid, i_c_addr, i_c_wdata});
   end
endmodule

// *** bench/tb.sv ***
`timescale 1ns/10ps
`define CHK(g, e) begin check_count++; if ((g) !== (e)) begin n_fail++; \
   $display("BAD t=%0t got %0h exp %0h", $time, g, e); end end
module tb;
   logic              clk;
   logic              rst;
   logic [5:0]        req;
   logic [5:0]        wr;
   logic [5:0][5:0]   mid;
   logic [5:0][2:0]   pri;
   logic [5:0][2:0]   slv;
   logic [5:0][31:0]  adr;
   logic [5:0][9:0]   len;
   logic [5:0][63:0]  wd;
   logic [5:0]        rdy;
   logic [5:0]        err;
   logic [5:0]        done;
   logic [3:0]        sv;
   logic [3:0]        sw;
   logic [3:0][5:0]   sid;
   logic [3:0][31:0]  sa;
   logic [3:0][6:0]   sb;
   logic [3:0][63:0]  swd;
   logic [3:0]        rrd;
   logic [3:0]        wrd;
   logic              cv;
   logic              cr;
   logic [31:0]       ca;
   logic [31:0]       cd;
   logic              cw;
   logic [5:0]        cm;
   int                n_fail = 0;
   int                check_count = 0;
   int                gap = 9;
   logic [5:0]        codes[17] = '{0, 1, 8, 9, 10, 11, 16, 17, 18, 19,
                                    20, 21, 22, 23, 32, 33, 34};
   ssf_fabric ssf_fabric_i (.i_ref_clk(clk), .i_rst(rst), .i_m_req(req),
      .i_m_mstid(mid), .i_m_prio(pri), .i_m_slave(slv), .i_m_wr(wr),
      .i_m_addr(adr), .i_m_len(len), .i_m_wdata(wd), .o_m_ready(rdy),
      .o_m_err(err), .o_m_done(done), .o_s_valid(sv), .o_s_wr(sw),
      .o_s_mstid(sid), .o_s_addr(sa), .o_s_bytes(sb), .o_s_wdata(swd),
      .i_s_rd_ready(rrd), .i_s_wr_ready(wrd), .o_c_valid(cv),
      .i_c_ready(cr), .o_c_wr(cw), .o_c_mstid(cm), .o_c_addr(ca),
      .o_c_wdata(cd));
   ssf_slave_model ssf_slave_model_i (.i_ref_clk(clk), .i_valid(sv),
      .i_wr(sw), .i_mstid(sid), .i_addr(sa), .i_bytes(sb), .i_wdata(swd),
      .o_rd_ready(rrd), .o_wr_ready(wrd), .i_c_valid(cv), .i_c_addr(ca),
      .i_c_wr(cw), .i_c_mstid(cm), .i_c_wdata(cd), .o_c_ready(cr));
   initial begin
      clk = 1'b0;
      forever #50 clk = ~clk;
   end
   // beats on the slow side never come closer than one per three clocks
   always @(posedge clk) begin
      if (cv && gap < 2)
         `CHK(gap, 2)
      gap <= (cv && cr) ? 0 : (gap < 9 ? gap + 1 : 9);
   end
   function automatic int bsz(input logic [5:0] id);
      case (id)
         16, 17, 33: return 32;
         18, 19, 32, 34: return 64;
         20, 21, 22, 23: return 16;
         default: return 32;
      endcase
   endfunction
   function automatic bit ok(input logic [5:0] id, input int s,
                             input logic w, input int n);
      if (n == 0)
         return 0;
      case (id)
         0, 1, 8: return s == 2;
         9, 10, 11: return s == 4;
         32, 33, 34: return s == 0 || s == 3;
         16, 17, 18, 19, 20, 21: return s != 3 && w == id[0];
         22, 23: return s >= 2 && w == id[0];
         default: return 0;
      endcase
   endfunction
   task automatic conclude();
      $display("checks %0d failures %0d", check_count, n_fail);
      if (n_fail == 0 && check_count > 0)
         $display("Testbench passed");
      else
         $display("Testbench failed");
      $finish;
   endtask
   task automatic tick(inout int k);
      @(negedge clk);
      k++;
      if (k > 400) begin
         n_fail++;
         conclude();
      end
   endtask
   task automatic run(input int p, input logic [5:0] id, input int pr,
                      input int s, input logic w, input int n);
      logic [31:0] a;
      logic [63:0] d;
      logic [112:0] g;
      logic [31:0] x;
      int          b;
      int          k;
      a = $urandom;
      d = {$urandom, $urandom};
      @(negedge clk);
      req[p] = 1'b1;
      mid[p] = id;
      pri[p] = 3'(pr);
      slv[p] = 3'(s);
      wr[p] = w;
      adr[p] = a;
      len[p] = 10'(n);
      wd[p] = d;
      @(negedge clk);
      req[p] = 1'b0;
      `CHK(err[p], !ok(id, s, w, n))
      `CHK(rdy[p], !ok(id, s, w, n))
      if (!ok(id, s, w, n))
         return;
      k = 0;
      while (!done[p]) tick(k);
      while (n > 0) begin
         b = n < bsz(id) ? n : bsz(id);
         k = 0;
         if (s == 4) begin
            for (int j = 0; j < (b + 3) / 4; j++) begin
               while (ssf_slave_model_i.cfg_q.size() == 0) tick(k);
               g = 113'(ssf_slave_model_i.cfg_q.pop_front());
               x = j[0] ? d[63:32] : d[31:0];
               `CHK(g, 113'({w, id, a + 32'(4 * j), x}))
            end
         end else begin
            while (ssf_slave_model_i.slot_q.size() == 0) tick(k);
            g = ssf_slave_model_i.slot_q.pop_front();
            `CHK(g, {w, 3'(s), id, a, 7'(b), d})
         end
         n -= b;
         a += 32'(b);
      end
   endtask
   // two masters, on slot 0 and on slot s1, send two bursts each
   task automatic duo(input int p0, input int p1, input int s1,
                      output logic [5:0] o[4]);
      logic [112:0] g;
      int          k;
      @(negedge clk);
      req[1:0] = 2'b11;
      mid[0] = 6'h20;
      mid[1] = 6'h22;
      pri[0] = 3'(p0);
      pri[1] = 3'(p1);
      slv[0] = 3'h0;
      slv[1] = 3'(s1);
      wr[1:0] = 2'b00;
      len[0] = 10'h080;
      len[1] = 10'h080;
      @(negedge clk);
      req = '0;
      @(negedge clk);
      `CHK(sv[0] && sv[s1], 1'b1)
      k = 0;
      while (ssf_slave_model_i.slot_q.size() < 4) tick(k);
      for (int i = 0; i < 4; i++) begin
         g = ssf_slave_model_i.slot_q.pop_front();
         o[i] = g[108:103];
      end
   endtask
   initial begin
      logic [5:0] id;
      logic [5:0] o[4];
      int         c;
      req = '0;
      wr = '0;
      mid = '0;
      pri = '0;
      slv = '0;
      adr = '0;
      len = '0;
      wd = '0;
      rst = 1'b1;
      void'($urandom(5215));
      repeat (4) @(posedge clk);
      @(negedge clk);
      rst = 1'b0;
      foreach (codes[i])
         for (int s = 0; s < 5; s++)
            if (ok(codes[i], s, codes[i][0], 70))
               run(i % 6, codes[i], 0, s, codes[i][0], 70);
      run(3, 6'h3f, 0, 0, 1'b0, 64);
      run(4, 6'h20, 0, 0, 1'b0, 0);
      for (int t = 0; t < 60; t++) begin
         id = ($urandom % 2) ? codes[$urandom % 17] : 6'($urandom);
         run($urandom % 6, id, $urandom % 8, $urandom % 5,
             ($urandom % 8 == 0) ? !id[0] : id[0], $urandom % 300);
      end
      duo(7, 0, 0, o);
      `CHK({o[0], o[1], o[2]}, {6'h22, 6'h22, 6'h20})
      duo(3, 3, 0, o);
      `CHK(o[0] != o[1] && o[1] != o[2] && o[2] != o[3], 1'b1)
      duo(0, 0, 3, o);
      c = 0;
      foreach (o[i]) c += int'(o[i] == 6'h20);
      `CHK(c, 2)
      conclude();
   end
endmodule

// *** src/ssf_bridge.sv ***
`timescale 1ns/10ps
module ssf_bridge (
   // clock and reset
   input  wire logic                       i_ref_clk,
   input  wire logic                       i_rst,
   // 64-bit fabric side
   input  wire logic                       i_valid,
   output logic                            o_ready,
   input  wire logic                       i_wr,
   input  wire logic [ssf_pkg::IDW-1:0]    i_mstid,
   input  wire logic [ssf_pkg::AW-1:0]     i_addr,
   input  wire logic [ssf_pkg::BW-1:0]     i_bytes,
   input  wire logic [ssf_pkg::DW-1:0]     i_wdata,
   // 32-bit configuration side
   output logic                            o_valid,
   input  wire logic                       i_ready,
   output logic                            o_wr,
   output logic [ssf_pkg::IDW-1:0]         o_mstid,
   output logic [ssf_pkg::AW-1:0]          o_addr,
   output logic [ssf_pkg::CW-1:0]          o_wdata
);
   typedef struct packed {
      ssf_pkg::ssf_cmd_s [ssf_pkg::CMD_DEPTH-1:0] q;
      logic [1:0]                                 wp;
      logic [1:0]                                 rp;
      logic [2:0]                                 cnt;
      logic [4:0]                                 beat;
      logic [1:0]                                 pace;
   } ssf_brg_s;

   ssf_brg_s          r_reg;
   ssf_brg_s          r_next;
   ssf_pkg::ssf_cmd_s head;
   logic [4:0]        nbeats;
   logic              push;
   logic              fire;
   logic              pop;

   assign head    = r_reg.q[r_reg.rp];
   assign nbeats  = 5'((head.bytes + 7'h03) >> 2);
   assign o_ready = r_reg.cnt != ssf_pkg::CMD_FULL;
   assign o_valid = r_reg.cnt != 3'h0 && r_reg.pace == 2'h0;
   assign o_wr    = head.wr;
   assign o_mstid = head.id;
   assign o_addr  = head.addr + {25'h000_0000, r_reg.beat, 2'h0};
   assign o_wdata = r_reg.beat[0] ? head.wdata[63:32]
                                  : head.wdata[31:0];
   assign push    = i_valid && o_ready;
   assign fire    = o_valid && i_ready;
   assign pop     = fire && (r_reg.beat + 5'h01 == nbeats);

   always_comb begin
      r_next = r_reg;
      if (push) begin
         r_next.q[r_reg.wp] = {i_wr, i_mstid, i_addr, i_bytes, i_wdata};
         r_next.wp = 2'(r_reg.wp + 2'h1);
      end
      // head is served to the end before the next entry
      if (fire) begin
         r_next.pace = ssf_pkg::PACE_LOAD;
         r_next.beat = 5'(r_reg.beat + 5'h01);
      end else if (r_reg.pace != 2'h0) begin
         r_next.pace = 2'(r_reg.pace - 2'h1);
      end
      if (pop) begin
         r_next.beat = 5'h00;
         r_next.rp = 2'(r_reg.rp + 2'h1);
      end
      r_next.cnt = 3'(r_reg.cnt + {2'h0, push} - {2'h0, pop});
   end

   always_ff @(posedge i_ref_clk or posedge i_rst) begin
      if (i_rst) begin
         r_reg <= '0;
      end else begin
         r_reg <= r_next;
      end
   end

   default clocking cb @(posedge i_ref_clk); endclocking
   default disable iff (i_rst);

   a_full_refuses: assert property (
      r_reg.cnt == ssf_pkg::CMD_FULL && !pop
      |=> r_reg.cnt == ssf_pkg::CMD_FULL && $stable(r_reg.wp))
      else $error("bridge accepts while full");
   a_slow_side_pace: assert property (
      fire |=> !o_valid [*2])
      else $error("bridge beats closer than fabric ratio");
   a_beat_held: assert property (
      o_valid && !i_ready |=> o_valid && $stable(o_addr))
      else $error("config beat dropped before accept");
   a_head_first: assert property (
      r_reg.cnt == 3'h0 && i_valid |=> o_mstid == $past(i_mstid))
      else $error("first queued command not at head");
   c_queue_full: cover property (r_reg.cnt == ssf_pkg::CMD_FULL);
endmodule

// *** src/ssf_fabric.sv ***
`timescale 1ns/10ps
module ssf_fabric (
   // clock and reset
   input  wire logic                                   i_ref_clk,
   input  wire logic                                   i_rst,
   // master request ports
   input  wire logic [ssf_pkg::NM-1:0]                 i_m_req,
   input  wire logic [ssf_pkg::NM-1:0][ssf_pkg::IDW-1:0] i_m_mstid,
   input  wire logic [ssf_pkg::NM-1:0][ssf_pkg::PW-1:0]  i_m_prio,
   input  wire logic [ssf_pkg::NM-1:0][ssf_pkg::SW-1:0]  i_m_slave,
   input  wire logic [ssf_pkg::NM-1:0]                 i_m_wr,
   input  wire logic [ssf_pkg::NM-1:0][ssf_pkg::AW-1:0]  i_m_addr,
   input  wire logic [ssf_pkg::NM-1:0][ssf_pkg::LW-1:0]  i_m_len,
   input  wire logic [ssf_pkg::NM-1:0][ssf_pkg::DW-1:0]  i_m_wdata,
   // master answers
   output logic [ssf_pkg::NM-1:0]                      o_m_ready,
   output logic [ssf_pkg::NM-1:0]                      o_m_err,
   output logic [ssf_pkg::NM-1:0]                      o_m_done,
   // 64-bit slave command ports
   output logic [ssf_pkg::NX-1:0]                      o_s_valid,
   output logic [ssf_pkg::NX-1:0]                      o_s_wr,
   output logic [ssf_pkg::NX-1:0][ssf_pkg::IDW-1:0]    o_s_mstid,
   output logic [ssf_pkg::NX-1:0][ssf_pkg::AW-1:0]     o_s_addr,
   output logic [ssf_pkg::NX-1:0][ssf_pkg::BW-1:0]     o_s_bytes,
   output logic [ssf_pkg::NX-1:0][ssf_pkg::DW-1:0]     o_s_wdata,
   input  wire logic [ssf_pkg::NX-1:0]                 i_s_rd_ready,
   input  wire logic [ssf_pkg::NX-1:0]                 i_s_wr_ready,
   // 32-bit configuration port
   output logic                                        o_c_valid,
   input  wire logic                                   i_c_ready,
   output logic                                        o_c_wr,
   output logic [ssf_pkg::IDW-1:0]                     o_c_mstid,
   output logic [ssf_pkg::AW-1:0]                      o_c_addr,
   output logic [ssf_pkg::CW-1:0]                      o_c_wdata
);
   typedef struct packed {
      logic [ssf_pkg::NM-1:0]                    act;
      logic [ssf_pkg::NM-1:0]                    err;
      logic [ssf_pkg::NM-1:0]                    done;
      logic [ssf_pkg::NM-1:0][ssf_pkg::IDW-1:0]  id;
      logic [ssf_pkg::NM-1:0][ssf_pkg::PW-1:0]   pri;
      logic [ssf_pkg::NM-1:0][ssf_pkg::SW-1:0]   dst;
      logic [ssf_pkg::NM-1:0]                    wr;
      logic [ssf_pkg::NM-1:0][ssf_pkg::AW-1:0]   addr;
      logic [ssf_pkg::NM-1:0][ssf_pkg::LW-1:0]   rem;
      logic [ssf_pkg::NM-1:0][ssf_pkg::DW-1:0]   wd;
      logic [ssf_pkg::NS-1:0]                    sv;
      logic [ssf_pkg::NS-1:0]                    swr;
      logic [ssf_pkg::NS-1:0][ssf_pkg::IDW-1:0]  sid;
      logic [ssf_pkg::NS-1:0][ssf_pkg::AW-1:0]   sad;
      logic [ssf_pkg::NS-1:0][ssf_pkg::BW-1:0]   sby;
      logic [ssf_pkg::NS-1:0][ssf_pkg::DW-1:0]   swd;
      logic [ssf_pkg::NS-1:0][2:0]               rr;
   } ssf_fab_s;

   ssf_fab_s               r_reg;
   ssf_fab_s               r_next;
   logic [ssf_pkg::NS-1:0] s_rdy;
   logic                   cfg_ready;

   // codes outside the table are refused
   function automatic logic id_ok(input logic [ssf_pkg::IDW-1:0] id,
                                  input logic wr);
      logic ok;
      ok = 1'b0;
      if (id <= ssf_pkg::ID_DATA) begin
         ok = 1'b1;
      end
      if (id >= ssf_pkg::ID_VIDEO && id <= ssf_pkg::ID_VCOP) begin
         ok = 1'b1;
      end
      if (id >= ssf_pkg::ID_TC_RD && id <= ssf_pkg::ID_TC_LAST) begin
         ok = wr == id[0];
      end
      if (id >= ssf_pkg::ID_ETH && id <= ssf_pkg::ID_USB) begin
         ok = 1'b1;
      end
      return ok;
   endfunction

   // connectivity set; request intake calls it only for valid codes
   function automatic logic may_reach(input logic [ssf_pkg::IDW-1:0] id,
                                      input logic [ssf_pkg::SW-1:0] d);
      logic ok;
      ok = 1'b0;
      if (id <= ssf_pkg::ID_DATA || id == ssf_pkg::ID_VIDEO) begin
         ok = d == ssf_pkg::S_VCOP;
      end else if (id <= ssf_pkg::ID_VCOP) begin
         ok = d == ssf_pkg::S_CFG;
      end else if (id >= ssf_pkg::ID_ETH) begin
         ok = d == ssf_pkg::S_INTMEM || d == ssf_pkg::S_DRAM;
      end else if (id >= ssf_pkg::ID_TC3_RD) begin
         ok = d == ssf_pkg::S_VCOP || d == ssf_pkg::S_CFG
              || d == ssf_pkg::S_DRAM;
      end else begin
         ok = d != ssf_pkg::S_DRAM && d <= ssf_pkg::S_CFG;
      end
      return ok;
   endfunction

   function automatic logic [ssf_pkg::BW-1:0] burst_max(
      input logic [ssf_pkg::IDW-1:0] id);
      logic [ssf_pkg::BW-1:0] b;
      b = ssf_pkg::B_DEF;
      if (id >= ssf_pkg::ID_TC_RD && id <= ssf_pkg::ID_TC_LAST) begin
         unique case (id[2:1])
            2'h0: b = ssf_pkg::B_TC0;
            2'h1: b = ssf_pkg::B_TC1;
            2'h2,
            2'h3: b = ssf_pkg::B_TC23;
         endcase
      end else if (id == ssf_pkg::ID_HOST) begin
         b = ssf_pkg::B_HOST;
      end else if (id == ssf_pkg::ID_ETH || id == ssf_pkg::ID_USB) begin
         b = ssf_pkg::B_NET;
      end
      return b;
   endfunction

   // separate read and write readiness on the wide slaves
   always_comb begin
      for (int s = 0; s < ssf_pkg::NX; s++) begin
         s_rdy[s] = r_reg.swr[s] ? i_s_wr_ready[s]
                                 : i_s_rd_ready[s];
      end
      s_rdy[ssf_pkg::S_CFG] = cfg_ready;
   end

   always_comb begin
      logic                   found;
      logic [2:0]             best;
      logic [ssf_pkg::PW-1:0] bp;
      logic [ssf_pkg::LW-1:0] bm;
      logic [ssf_pkg::LW-1:0] cur;
      int                     j;
      found  = 1'b0;
      best   = 3'h0;
      bp     = '0;
      bm     = '0;
      cur    = '0;
      j      = 0;
      r_next = r_reg;
      r_next.err  = '0;
      r_next.done = '0;
      // request intake: a master port holds one transaction
      for (int m = 0; m < ssf_pkg::NM; m++) begin
         if (!r_reg.act[m] && i_m_req[m]) begin
            if (!id_ok(i_m_mstid[m], i_m_wr[m])
                || !may_reach(i_m_mstid[m], i_m_slave[m])
                || i_m_len[m] == '0) begin
               r_next.err[m] = 1'b1;
            end else begin
               r_next.act[m]  = 1'b1;
               r_next.id[m]   = i_m_mstid[m];
               r_next.pri[m]  = i_m_prio[m];
               r_next.dst[m]  = i_m_slave[m];
               r_next.wr[m]   = i_m_wr[m];
               r_next.addr[m] = i_m_addr[m];
               r_next.rem[m]  = i_m_len[m];
               r_next.wd[m]   = i_m_wdata[m];
            end
         end
      end
      // each slave slot arbitrates on its own
      for (int s = 0; s < ssf_pkg::NS; s++) begin
         if (r_reg.sv[s] && s_rdy[s]) begin
            r_next.sv[s] = 1'b0;
         end
         // a new winner only once the held burst is gone
         if (!r_reg.sv[s] || s_rdy[s]) begin
            found = 1'b0;
            best  = 3'h0;
            bp    = '0;
            // scan starts past the last winner, strict compare
            for (int i = 1; i <= ssf_pkg::NM; i++) begin
               j = int'(r_reg.rr[s]) + i;
               if (j >= ssf_pkg::NM) begin
                  j = j - ssf_pkg::NM;
               end
               if (r_reg.act[j] && r_reg.dst[j] == 3'(s)
                   && (!found || r_reg.pri[j] < bp)) begin
                  found = 1'b1;
                  best  = 3'(j);
                  bp    = r_reg.pri[j];
               end
            end
            if (found) begin
               bm  = {3'h0, burst_max(r_reg.id[best])};
               cur = (r_reg.rem[best] < bm) ? r_reg.rem[best] : bm;
               r_next.sv[s]  = 1'b1;
               r_next.swr[s] = r_reg.wr[best];
               r_next.sid[s] = r_reg.id[best];
               r_next.sad[s] = r_reg.addr[best];
               r_next.sby[s] = cur[ssf_pkg::BW-1:0];
               r_next.swd[s] = r_reg.wd[best];
               r_next.rr[s]  = best;
               r_next.addr[best] = r_reg.addr[best]
                                   + {22'h00_0000, cur};
               r_next.rem[best]  = r_reg.rem[best] - cur;
               if (r_reg.rem[best] == cur) begin
                  r_next.act[best]  = 1'b0;
                  r_next.done[best] = 1'b1;
               end
            end
         end
      end
   end

   always_ff @(posedge i_ref_clk or posedge i_rst) begin
      if (i_rst) begin
         r_reg <= '0;
      end else begin
         r_reg <= r_next;
      end
   end

   // each master port is its own entry in the vectors, whatever code it sends
   assign o_m_ready = ~r_reg.act;
   assign o_m_err   = r_reg.err;
   assign o_m_done  = r_reg.done;
   assign o_s_valid = r_reg.sv[ssf_pkg::NX-1:0];
   assign o_s_wr    = r_reg.swr[ssf_pkg::NX-1:0];
   assign o_s_mstid = r_reg.sid[ssf_pkg::NX-1:0];
   assign o_s_addr  = r_reg.sad[ssf_pkg::NX-1:0];
   assign o_s_bytes = r_reg.sby[ssf_pkg::NX-1:0];
   assign o_s_wdata = r_reg.swd[ssf_pkg::NX-1:0];

   // configuration slave sits behind the narrow, slow bridge
   ssf_bridge u_cfg_bridge (
      .i_ref_clk (i_ref_clk),
      .i_rst     (i_rst),
      .i_valid   (r_reg.sv[ssf_pkg::S_CFG]),
      .o_ready   (cfg_ready),
      .i_wr      (r_reg.swr[ssf_pkg::S_CFG]),
      .i_mstid   (r_reg.sid[ssf_pkg::S_CFG]),
      .i_addr    (r_reg.sad[ssf_pkg::S_CFG]),
      .i_bytes   (r_reg.sby[ssf_pkg::S_CFG]),
      .i_wdata   (r_reg.swd[ssf_pkg::S_CFG]),
      .o_valid   (o_c_valid),
      .i_ready   (i_c_ready),
      .o_wr      (o_c_wr),
      .o_mstid   (o_c_mstid),
      .o_addr    (o_c_addr),
      .o_wdata   (o_c_wdata)
   );

   default clocking cb @(posedge i_ref_clk); endclocking
   default disable iff (i_rst);

   // a refusal leaves the port idle, so the master may retry at once
   for (genvar g = 0; g < ssf_pkg::NM; g++) begin : g_mchk
      a_refuse_bad_id: assert property (
         i_m_req[g] && o_m_ready[g] && !id_ok(i_m_mstid[g], i_m_wr[g])
         |=> o_m_err[g] && o_m_ready[g])
         else $error("bad master code not refused");
      a_err_not_loaded: assert property (
         o_m_err[g] |-> o_m_ready[g] && !o_m_done[g])
         else $error("refused request was taken");
      a_accept_good: assert property (
         i_m_req[g] && o_m_ready[g] && id_ok(i_m_mstid[g], i_m_wr[g])
         && may_reach(i_m_mstid[g], i_m_slave[g]) && i_m_len[g] != '0
         |=> !o_m_ready[g] && !o_m_err[g])
         else $error("valid request not taken");
      a_pair_refused: assert property (
         i_m_req[g] && o_m_ready[g]
         && !may_reach(i_m_mstid[g], i_m_slave[g])
         |=> o_m_err[g])
         else $error("forbidden pair not refused");
      a_empty_refused: assert property (
         i_m_req[g] && o_m_ready[g] && i_m_len[g] == '0 |=> o_m_err[g])
         else $error("empty transaction not refused");
   end

   for (genvar g = 0; g < ssf_pkg::NX; g++) begin : g_schk
      a_pair_allowed: assert property (
         o_s_valid[g] |-> may_reach(o_s_mstid[g], 3'(g)))
         else $error("forbidden pair forwarded");
      a_burst_capped: assert property (
         o_s_valid[g] |-> o_s_bytes[g] <= burst_max(o_s_mstid[g])
                          && o_s_bytes[g] != '0)
         else $error("burst exceeds master default");
      a_tc_direction: assert property (
         o_s_valid[g] && o_s_mstid[g][5:3] == 3'h2
         |-> o_s_wr[g] == o_s_mstid[g][0])
         else $error("dma code does not match direction");
      a_burst_held: assert property (
         o_s_valid[g] && !s_rdy[g]
         |=> o_s_valid[g] && $stable(o_s_mstid[g])
             && $stable(o_s_addr[g]))
         else $error("burst switched before boundary");
   end

   // an idle slot serves a waiter at once, whatever the other slots do
   // a wrong pick shows as a worse grant while a better one waits
   for (genvar s = 0; s < ssf_pkg::NS; s++) begin : g_arb
      for (genvar m = 0; m < ssf_pkg::NM; m++) begin : g_cand
         a_slot_serves: assert property (
            !r_reg.sv[s] && r_reg.act[m] && r_reg.dst[m] == 3'(s)
            |=> r_reg.sv[s])
            else $error("idle slot left a waiting master");
         a_prio_order: assert property (
            (!r_reg.sv[s] || s_rdy[s]) && r_reg.act[m]
            && r_reg.dst[m] == 3'(s)
            |-> r_reg.pri[r_next.rr[s]] <= r_reg.pri[m])
            else $error("worse priority granted");
      end
   end

   // cfg slot waits, unchanged, while the bridge queue is full
   a_cfg_backpress: assert property (
      r_reg.sv[ssf_pkg::S_CFG] && !cfg_ready
      |=> r_reg.sv[ssf_pkg::S_CFG]
          && $stable(r_reg.sad[ssf_pkg::S_CFG]))
      else $error("cfg burst lost while bridge full");

   c_concurrent_pairs: cover property (o_s_valid[0] && o_s_valid[3]);
   c_refused: cover property (o_m_err[1]);
   c_done: cover property (o_m_done[0] ##1 o_m_ready[0]);
   c_cfg_stall: cover property (r_reg.sv[ssf_pkg::S_CFG] && !cfg_ready);
endmodule

// *** src/ssf_pkg.sv ***
package ssf_pkg;
   // port counts and widths
   localparam int NM        = 6;
   localparam int NS        = 5;
   localparam int NX        = 4;
   localparam int IDW       = 6;
   localparam int AW        = 32;
   localparam int LW        = 10;
   localparam int DW        = 64;
   localparam int CW        = 32;
   localparam int BW        = 7;
   localparam int PW        = 3;
   localparam int SW        = 3;

   // slave indices, 64-bit ports first
   localparam logic [SW-1:0] S_INTMEM = 3'h0;
   localparam logic [SW-1:0] S_CODEC  = 3'h1;
   localparam logic [SW-1:0] S_VCOP   = 3'h2;
   localparam logic [SW-1:0] S_DRAM   = 3'h3;
   localparam logic [SW-1:0] S_CFG    = 3'h4;

   // master identifiers
   localparam logic [IDW-1:0] ID_INSTR   = 6'h00;
   localparam logic [IDW-1:0] ID_DATA    = 6'h01;
   localparam logic [IDW-1:0] ID_VIDEO   = 6'h08;
   localparam logic [IDW-1:0] ID_CODEC   = 6'h09;
   localparam logic [IDW-1:0] ID_DMACC   = 6'h0a;
   localparam logic [IDW-1:0] ID_VCOP    = 6'h0b;
   localparam logic [IDW-1:0] ID_TC_RD   = 6'h10;
   localparam logic [IDW-1:0] ID_TC3_RD  = 6'h16;
   localparam logic [IDW-1:0] ID_TC_LAST = 6'h17;
   localparam logic [IDW-1:0] ID_ETH     = 6'h20;
   localparam logic [IDW-1:0] ID_HOST    = 6'h21;
   localparam logic [IDW-1:0] ID_USB     = 6'h22;

   // default burst sizes in bytes
   localparam logic [BW-1:0] B_TC0  = 7'h20;
   localparam logic [BW-1:0] B_TC1  = 7'h40;
   localparam logic [BW-1:0] B_TC23 = 7'h10;
   localparam logic [BW-1:0] B_HOST = 7'h20;
   localparam logic [BW-1:0] B_NET  = 7'h40;
   localparam logic [BW-1:0] B_DEF  = 7'h20;

   // bridge
   localparam int            CMD_DEPTH = 4;
   localparam int            FAB_DIV   = 3;
   localparam logic [1:0]    PACE_LOAD = 2'(FAB_DIV - 1);
   localparam logic [2:0]    CMD_FULL  = 3'(CMD_DEPTH);

   typedef struct packed {
      logic           wr;
      logic [IDW-1:0] id;
      logic [AW-1:0]  addr;
      logic [BW-1:0]  bytes;
      logic [DW-1:0]  wdata;
   } ssf_cmd_s;
endpackage
